// ### src/cmf_params.svh
// Constants for the CAN message FIFO control block.
// Operation
// - Payload size code 000..111 selects 8,12,16,20,24,32,48 or 64 data bytes.
// - Five-bit depth field gives depth of field value plus one messages.
// - Retry code, honoured only under global limit: 00 none, 01 three, 1x unlimited.
// - Five-bit transmit priority, zero lowest, all ones highest.
// - Payload, depth, direction and time-stamp enable change only in Configuration mode.
// - Writing one to clear request resets FIFO; hardware then clears it; zero ignored.
// - Clear request stays set in Configuration mode, clears itself in Normal mode.
// - Transmit send request starts sending; self-clears once every queued message is sent.
// - Writing zero to a set send request asks for an abort.
// - In a receive FIFO, send request writes do nothing.
// - Transmit FIFO: pointer advance moves the head by exactly one slot.
// - Receive FIFO: pointer advance moves the tail by exactly one slot.
// - Direction one means transmit, zero receive; dependent fields follow it.
// - Auto remote reply on: received remote request sets send request; off: untouched.
// - Time-stamp enable set stores a time stamp in each received message.
// - Low three enables gate direction-dependent level interrupts.
// - Slot index gives next slot to send, or next slot to fill.
// - Status reports aborted, lost arbitration and bus error per message.
// - Those status bits clear when send request sets, or on host writing zero.
// - Status and send request update on completion, abort and FIFO reset.
// - Attempts-exhausted flag flags run-out retries; reads zero for receive FIFOs.
// - Overflow flag sets on receive overflow; reads zero for transmit FIFOs.
// - Half flag means at most half full (transmit) or at least half (receive).
// - FIFO zero is the transmit queue and never receives.
`ifndef CMF_PARAMS_SVH
`define CMF_PARAMS_SVH

// Register select values on the register port.
`define CMF_REG_CONTROL 1'b0
`define CMF_REG_STATUS 1'b1

// Control register field positions.
`define CMF_PLSZ_LSB 29
`define CMF_DEPTH_LSB 24
`define CMF_RETRY_LSB 21
`define CMF_PRIO_LSB 16
`define CMF_CLEAR_BIT 10
`define CMF_SEND_BIT 9
`define CMF_ADV_BIT 8
`define CMF_DIR_BIT 7
`define CMF_RTR_BIT 6
`define CMF_TS_BIT 5
`define CMF_IE_LSB 0

// Status register field positions.
`define CMF_INDEX_LSB 8
`define CMF_ABORT_BIT 7
`define CMF_LARB_BIT 6
`define CMF_BERR_BIT 5
`define CMF_EXH_BIT 4
`define CMF_OVF_BIT 3

// Reset values and counts.
`define CMF_RETRY_RESET 2'h3
`define CMF_CLEAR_RESET 1'b1
`define CMF_RETRY_LIMIT 2'h3
`define CMF_PTR_ZERO 5'h00
`define CMF_COUNT_ZERO 6'h00
`define CMF_COUNT_ONE 6'h01
`define CMF_TXQ_INDEX 5'h00

`endif

// ### src/cmf_pkg.sv
// Types for the CAN message FIFO control block.
package cmf_pkg;

    typedef enum logic [1:0] {
        CMF_RETRY_NONE = 2'b00,
        CMF_RETRY_THREE = 2'b01,
        CMF_RETRY_ENDLESS = 2'b10,
        CMF_RETRY_ENDLESS2 = 2'b11
    } cmf_retry_t;

    typedef struct packed {
        logic [2:0] payload_size_sel;
        logic [4:0] fifo_depth_sel;
        cmf_retry_t retry_policy;
        logic [4:0] tx_priority;
        logic fifo_clear_req;
        logic send_request;
        logic direction_select;
        logic auto_remote_reply_en;
        logic rx_timestamp_en;
        logic [4:0] ie;
        logic [4:0] head;
        logic [4:0] tail;
        logic [5:0] count;
        logic [1:0] retries_left;
        logic aborted_flag;
        logic lost_arbitration_flag;
        logic bus_error_flag;
        logic retries_exhausted_flag;
        logic overflow_flag;
        logic [2:0] level_flags;
        logic link_prev;
        logic abort_req;
        logic retry_allowed;
        logic [6:0] payload_bytes;
        logic [5:0] depth_msgs;
        logic [4:0] irq;
        logic [31:0] rdata;
        logic rvalid;
    } cmf_state_t;

endpackage : cmf_pkg

// ### src/cmf_sync.sv
// Two-stage synchroniser for signals from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module cmf_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } cmf_sync_t;

    cmf_sync_t s;
    cmf_sync_t next_s;

    always_comb begin
        next_s = s;
        next_s.meta = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign q = s.stable;
endmodule : cmf_sync
`default_nettype wire

// ### src/cmf_level.sv
// Direction-dependent fill-level flags of one message FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "cmf_params.svh"
module cmf_level (
    // Fill state
    input wire logic [5:0] count,
    input wire logic [4:0] depth_sel,
    input wire logic is_tx,
    // Flags: empty/full, half, not-full/not-empty
    output logic [2:0] flags
);
    logic [5:0] depth;
    logic [6:0] twice;

    always_comb begin
        depth = {1'b0, depth_sel} + `CMF_COUNT_ONE;
        twice = {count, 1'b0};
        if (is_tx) begin
            flags[2] = (count == `CMF_COUNT_ZERO);
            flags[1] = (twice <= {1'b0, depth});
            flags[0] = (count != depth);
        end else begin
            flags[2] = (count == depth);
            flags[1] = (twice >= {1'b0, depth});
            flags[0] = (count != `CMF_COUNT_ZERO);
        end
    end
endmodule : cmf_level
`default_nettype wire

// ### src/cmf_fifo_ctrl.sv
// Control and status registers of one CAN message FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "cmf_params.svh"
module cmf_fifo_ctrl #(
    parameter logic [4:0] FIFO_INDEX = 5'h01
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Controller mode
    input wire logic cfg_mode,
    input wire logic global_retry_limit_en,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Protocol engine events, held for a full link clock period
    input wire logic link_clk,
    input wire logic ev_tx_done,
    input wire logic ev_tx_abort,
    input wire logic ev_lost_arb,
    input wire logic ev_bus_err,
    input wire logic ev_rx_msg,
    input wire logic ev_rtr_rx,
    // Controls towards engine and RAM
    output logic send_request,
    output logic abort_req,
    output logic retry_allowed,
    output logic [4:0] tx_priority,
    output logic [6:0] payload_bytes,
    output logic [5:0] depth_msgs,
    output logic [4:0] head_index,
    output logic [4:0] tail_index,
    output logic [4:0] message_slot_index,
    output logic ts_store,
    output logic is_transmit,
    // Interrupt requests: exhausted, overflow, three level flags
    output logic [4:0] irq
);
    cmf_pkg::cmf_state_t s;
    cmf_pkg::cmf_state_t next_s;
    logic [6:0] synced;
    logic [2:0] level;

    function automatic logic [6:0] payload_size_sel_bytes(input logic [2:0] code);
        case (code)
            3'h0: payload_size_sel_bytes = 7'h08;
            3'h1: payload_size_sel_bytes = 7'h0c;
            3'h2: payload_size_sel_bytes = 7'h10;
            3'h3: payload_size_sel_bytes = 7'h14;
            3'h4: payload_size_sel_bytes = 7'h18;
            3'h5: payload_size_sel_bytes = 7'h20;
            3'h6: payload_size_sel_bytes = 7'h30;
            default: payload_size_sel_bytes = 7'h40;
        endcase
    endfunction : payload_size_sel_bytes

    function automatic logic retry_ok(input logic limit_en, input cmf_pkg::cmf_retry_t pol,
                                      input logic [1:0] left);
        if (!limit_en) begin
            retry_ok = 1'b1;
        end else begin
            case (pol)
                cmf_pkg::CMF_RETRY_NONE: retry_ok = 1'b0;
                cmf_pkg::CMF_RETRY_THREE: retry_ok = (left != 2'h0);
                default: retry_ok = 1'b1;
            endcase
        end
    endfunction : retry_ok

    function automatic logic [4:0] ptr_step(input logic [4:0] ptr, input logic [4:0] last);
        ptr_step = (ptr == last) ? `CMF_PTR_ZERO : ptr + 5'h01;
    endfunction : ptr_step

    function automatic logic [5:0] depth_of(input logic [4:0] sel);
        depth_of = {1'b0, sel} + `CMF_COUNT_ONE;
    endfunction : depth_of

    // The link clock and the event lines go through the same two stages, so an
    // event sampled at a detected link edge lines up with that edge.
    cmf_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .d({link_clk, ev_rtr_rx, ev_rx_msg, ev_bus_err, ev_lost_arb, ev_tx_abort, ev_tx_done}),
        .q(synced)
    );

    // Level flags come from the registered count, so they trail it by a cycle.
    cmf_level u_level (
        .count(s.count),
        .depth_sel(s.fifo_depth_sel),
        .is_tx(s.direction_select),
        .flags(level)
    );

    always_comb begin
        logic link_rise;
        logic [5:0] ev;
        logic is_tx;
        logic wr_ctl;
        logic wr_sta;
        logic full;
        logic empty;
        logic adv;
        logic send_set;
        logic exh_eff;
        logic ovf_eff;
        next_s = s;
        link_rise = 1'b0;
        ev = 6'h00;
        is_tx = s.direction_select;
        wr_ctl = reg_wr && (reg_addr == `CMF_REG_CONTROL);
        wr_sta = reg_wr && (reg_addr == `CMF_REG_STATUS);
        full = (s.count == depth_of(s.fifo_depth_sel));
        empty = (s.count == `CMF_COUNT_ZERO);
        adv = 1'b0;
        send_set = 1'b0;
        exh_eff = 1'b0;
        ovf_eff = 1'b0;
        next_s.abort_req = 1'b0;
        next_s.rvalid = 1'b0;

        link_rise = synced[6] && !s.link_prev;
        next_s.link_prev = synced[6];
        if (link_rise) begin
            ev = synced[5:0];
        end

        // Sizing and direction are frozen outside Configuration mode.
        if (wr_ctl && cfg_mode) begin
            if (reg_be[3]) begin
                next_s.payload_size_sel = reg_wdata[`CMF_PLSZ_LSB +: 3];
                next_s.fifo_depth_sel = reg_wdata[`CMF_DEPTH_LSB +: 5];
            end
            if (reg_be[0]) begin
                // The transmit queue can never be turned into a receiver.
                next_s.direction_select = reg_wdata[`CMF_DIR_BIT] ||
                                          (FIFO_INDEX == `CMF_TXQ_INDEX);
                next_s.rx_timestamp_en = reg_wdata[`CMF_TS_BIT];
            end
        end
        if (wr_ctl && reg_be[2]) begin
            next_s.retry_policy = cmf_pkg::cmf_retry_t'(reg_wdata[`CMF_RETRY_LSB +: 2]);
            next_s.tx_priority = reg_wdata[`CMF_PRIO_LSB +: 5];
        end
        if (wr_ctl && reg_be[0]) begin
            next_s.auto_remote_reply_en = reg_wdata[`CMF_RTR_BIT];
            next_s.ie = reg_wdata[`CMF_IE_LSB +: 5];
        end

        // Byte 1: clear request, send request, pointer advance.
        if (wr_ctl && reg_be[1]) begin
            if (reg_wdata[`CMF_CLEAR_BIT]) begin
                next_s.fifo_clear_req = 1'b1;
            end
            if (is_tx && !cfg_mode && !s.fifo_clear_req) begin
                if (reg_wdata[`CMF_SEND_BIT] && !s.send_request) begin
                    send_set = 1'b1;
                end else if (!reg_wdata[`CMF_SEND_BIT] && s.send_request) begin
                    next_s.send_request = 1'b0;
                    next_s.abort_req = 1'b1;
                end
            end
            adv = reg_wdata[`CMF_ADV_BIT] && !cfg_mode && !s.fifo_clear_req;
        end

        // Host clears of status bits go first so that a same-cycle event wins.
        if (wr_sta && reg_be[0]) begin
            next_s.aborted_flag = s.aborted_flag && reg_wdata[`CMF_ABORT_BIT];
            next_s.lost_arbitration_flag = s.lost_arbitration_flag &&
                                           reg_wdata[`CMF_LARB_BIT];
            next_s.bus_error_flag = s.bus_error_flag && reg_wdata[`CMF_BERR_BIT];
            next_s.retries_exhausted_flag = s.retries_exhausted_flag &&
                                            reg_wdata[`CMF_EXH_BIT];
            next_s.overflow_flag = s.overflow_flag && reg_wdata[`CMF_OVF_BIT];
        end

        // A remote request answered automatically.
        if (ev[5] && is_tx && s.auto_remote_reply_en && !s.send_request) begin
            send_set = 1'b1;
        end
        if (send_set) begin
            next_s.send_request = 1'b1;
            next_s.aborted_flag = 1'b0;
            next_s.lost_arbitration_flag = 1'b0;
            next_s.bus_error_flag = 1'b0;
            next_s.retries_left = `CMF_RETRY_LIMIT;
        end

        if (is_tx) begin
            if (adv && !full) begin
                next_s.head = ptr_step(s.head, s.fifo_depth_sel);
                next_s.count = next_s.count + `CMF_COUNT_ONE;
            end
            if (ev[0] && !empty) begin
                next_s.tail = ptr_step(s.tail, s.fifo_depth_sel);
                next_s.count = next_s.count - `CMF_COUNT_ONE;
                next_s.aborted_flag = 1'b0;
                next_s.retries_left = `CMF_RETRY_LIMIT;
                if (s.count == `CMF_COUNT_ONE) begin
                    next_s.send_request = 1'b0;
                end
            end
            if (ev[1]) begin
                next_s.aborted_flag = 1'b1;
                next_s.send_request = 1'b0;
            end
            if (ev[2] || ev[3]) begin
                next_s.lost_arbitration_flag = next_s.lost_arbitration_flag || ev[2];
                next_s.bus_error_flag = next_s.bus_error_flag || ev[3];
                if (!s.retry_allowed) begin
                    // No attempt left: give up on the message.
                    next_s.retries_exhausted_flag = 1'b1;
                    next_s.aborted_flag = 1'b1;
                    next_s.send_request = 1'b0;
                end else if (global_retry_limit_en &&
                             s.retry_policy == cmf_pkg::CMF_RETRY_THREE) begin
                    next_s.retries_left = s.retries_left - 2'h1;
                end
            end
        end else begin
            if (adv && !empty) begin
                next_s.tail = ptr_step(s.tail, s.fifo_depth_sel);
                next_s.count = next_s.count - `CMF_COUNT_ONE;
            end
            if (ev[4]) begin
                if (full) begin
                    next_s.overflow_flag = 1'b1;
                end else begin
                    next_s.head = ptr_step(s.head, s.fifo_depth_sel);
                    next_s.count = next_s.count + `CMF_COUNT_ONE;
                end
            end
        end

        // Configuration mode holds the FIFO in reset; Normal mode finishes it.
        if (cfg_mode || s.fifo_clear_req) begin
            next_s.fifo_clear_req = cfg_mode;
            next_s.head = `CMF_PTR_ZERO;
            next_s.tail = `CMF_PTR_ZERO;
            next_s.count = `CMF_COUNT_ZERO;
            next_s.send_request = 1'b0;
            next_s.aborted_flag = 1'b0;
            next_s.lost_arbitration_flag = 1'b0;
            next_s.bus_error_flag = 1'b0;
            next_s.retries_exhausted_flag = 1'b0;
            next_s.overflow_flag = 1'b0;
            next_s.retries_left = `CMF_RETRY_LIMIT;
            next_s.abort_req = s.send_request;
        end

        exh_eff = s.retries_exhausted_flag && s.direction_select;
        ovf_eff = s.overflow_flag && !s.direction_select;
        next_s.level_flags = level;
        next_s.irq = {exh_eff, ovf_eff, s.level_flags} & s.ie;
        next_s.retry_allowed = retry_ok(global_retry_limit_en, s.retry_policy,
                                        next_s.retries_left);
        next_s.payload_bytes = payload_size_sel_bytes(s.payload_size_sel);
        next_s.depth_msgs = depth_of(s.fifo_depth_sel);

        if (reg_rd) begin
            next_s.rvalid = 1'b1;
            if (reg_addr == `CMF_REG_CONTROL) begin
                next_s.rdata = '0;
                next_s.rdata[`CMF_PLSZ_LSB +: 3] = s.payload_size_sel;
                next_s.rdata[`CMF_DEPTH_LSB +: 5] = s.fifo_depth_sel;
                next_s.rdata[`CMF_RETRY_LSB +: 2] = s.retry_policy;
                next_s.rdata[`CMF_PRIO_LSB +: 5] = s.tx_priority;
                next_s.rdata[`CMF_CLEAR_BIT] = s.fifo_clear_req;
                next_s.rdata[`CMF_SEND_BIT] = s.send_request;
                next_s.rdata[`CMF_DIR_BIT] = s.direction_select;
                next_s.rdata[`CMF_RTR_BIT] = s.auto_remote_reply_en;
                next_s.rdata[`CMF_TS_BIT] = s.rx_timestamp_en;
                next_s.rdata[`CMF_IE_LSB +: 5] = s.ie;
            end else begin
                next_s.rdata = '0;
                // Transmit shows the next slot to send, receive the next to fill.
                next_s.rdata[`CMF_INDEX_LSB +: 5] = s.direction_select ? s.tail : s.head;
                next_s.rdata[`CMF_ABORT_BIT] = s.aborted_flag;
                next_s.rdata[`CMF_LARB_BIT] = s.lost_arbitration_flag;
                next_s.rdata[`CMF_BERR_BIT] = s.bus_error_flag;
                next_s.rdata[`CMF_EXH_BIT] = exh_eff;
                next_s.rdata[`CMF_OVF_BIT] = ovf_eff;
                next_s.rdata[2:0] = s.level_flags;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.retry_policy <= cmf_pkg::cmf_retry_t'(`CMF_RETRY_RESET);
            s.fifo_clear_req <= `CMF_CLEAR_RESET;
            s.direction_select <= (FIFO_INDEX == `CMF_TXQ_INDEX);
            s.retries_left <= `CMF_RETRY_LIMIT;
            s.payload_bytes <= 7'h08;
            s.depth_msgs <= `CMF_COUNT_ONE;
            s.retry_allowed <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign send_request = s.send_request;
    assign abort_req = s.abort_req;
    assign retry_allowed = s.retry_allowed;
    assign tx_priority = s.tx_priority;
    assign payload_bytes = s.payload_bytes;
    assign depth_msgs = s.depth_msgs;
    assign head_index = s.head;
    assign tail_index = s.tail;
    assign message_slot_index = s.direction_select ? s.tail : s.head;
    assign ts_store = s.rx_timestamp_en && !s.direction_select;
    assign is_transmit = s.direction_select;
    assign irq = s.irq;
endmodule : cmf_fifo_ctrl
`default_nettype wire

// ### verif/cmf_fifo_ctrl_monitor.sv
// Port assertions for the message FIFO control block.
`timescale 1ns/1ps
`default_nettype none
module cmf_fifo_ctrl_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Observed ports
    input wire logic cfg_mode,
    input wire logic send_request,
    input wire logic [6:0] payload_bytes,
    input wire logic [5:0] depth_msgs,
    input wire logic [4:0] head_index,
    input wire logic [4:0] tail_index,
    input wire logic [4:0] message_slot_index,
    input wire logic ts_store,
    input wire logic is_transmit,
    input wire logic [4:0] irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_payload;
        payload_bytes inside {7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
    endproperty
    a_payload: assert property (p_payload) else $error("payload size off table");
    property p_depth;
        depth_msgs >= 6'h01 && depth_msgs <= 6'h20;
    endproperty
    a_depth: assert property (p_depth) else $error("depth out of range");
    // Three idle cycles let any write from the last configuration cycle land first.
    property p_cfg;
        !cfg_mode [*3] |=> $stable(payload_bytes) && $stable(depth_msgs) && $stable(is_transmit);
    endproperty
    a_cfg: assert property (p_cfg) else $error("sizing changed outside configuration");
    property p_rx_send;
        !is_transmit [*2] |-> !send_request;
    endproperty
    a_rx_send: assert property (p_rx_send) else $error("send request set in receive");
    property p_head;
        $changed(head_index) |-> head_index == $past(head_index) + 5'h01 || head_index == 5'h00;
    endproperty
    a_head: assert property (p_head) else $error("head moved by more than one");
    property p_tail;
        $changed(tail_index) |-> tail_index == $past(tail_index) + 5'h01 || tail_index == 5'h00;
    endproperty
    a_tail: assert property (p_tail) else $error("tail moved by more than one");
    property p_ts;
        ts_store |-> !is_transmit;
    endproperty
    a_ts: assert property (p_ts) else $error("time stamp stored in transmit");
    property p_index;
        message_slot_index == (is_transmit ? tail_index : head_index);
    endproperty
    a_index: assert property (p_index) else $error("slot index wrong pointer");
    property p_ovf;
        is_transmit [*3] |-> !irq[3];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow request in transmit");
endmodule : cmf_fifo_ctrl_monitor
`default_nettype wire

// ### verif/cmf_engine_model.sv
// Protocol engine stand-in delivering event frames on the link clock.
`timescale 1ns/1ps
`default_nettype none
module cmf_engine_model (
    // Link side
    output logic link_clk,
    output logic [5:0] ev
);
    initial begin
        link_clk = 1'h0;
        ev = 6'h00;
    end
    // The link clock only runs inside a frame; events straddle the rising edge.
    task automatic frame(input logic [5:0] e);
        ev = e;
        #80;
        link_clk = 1'h1;
        #80;
        link_clk = 1'h0;
        // Idle lines flip so a stale value is never taken for a fresh event.
        ev = ~e;
    endtask : frame
endmodule : cmf_engine_model
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the message FIFO control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'h0, rst_b = 1'h0, ce = 1'h1, cfg_mode = 1'h1, global_retry_limit_en = 1'h1;
    logic reg_wr = 1'h0, reg_rd = 1'h0, reg_addr = 1'h0, link_clk, reg_rvalid;
    logic send_request, abort_req, retry_allowed, ts_store, is_transmit, abort_seen = 1'h0;
    logic [3:0] reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [5:0] ev, depth_msgs;
    logic [6:0] payload_bytes;
    logic [4:0] tx_priority, head_index, tail_index, message_slot_index, irq;
    logic [6:0] sizes [8] = '{7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
    int errors = 0, n_checks = 0, cyc = 0;
    cmf_fifo_ctrl #(.FIFO_INDEX(5'h01)) DUT (.clk, .rst_b, .ce, .cfg_mode,
        .global_retry_limit_en, .reg_wr, .reg_rd, .reg_addr, .reg_be, .reg_wdata, .reg_rdata,
        .reg_rvalid, .link_clk, .ev_tx_done(ev[0]), .ev_tx_abort(ev[1]), .ev_lost_arb(ev[2]),
        .ev_bus_err(ev[3]), .ev_rx_msg(ev[4]), .ev_rtr_rx(ev[5]), .send_request, .abort_req,
        .retry_allowed, .tx_priority, .payload_bytes, .depth_msgs, .head_index, .tail_index,
        .message_slot_index, .ts_store, .is_transmit, .irq);
    cmf_engine_model ENG (.link_clk, .ev);
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (abort_req === 1'h1) abort_seen <= 1'h1;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic a, input logic [3:0] be, input logic [31:0] w);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_be <= be;
        reg_wdata <= w;
        @(posedge clk);
        reg_wr <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input logic a);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk("reg_rvalid", reg_rvalid, 32'h1);
        d = reg_rdata;
    endtask : rd
    task automatic step(input logic [5:0] e);
        ENG.frame(e);
        @(posedge clk);
        #1;
    endtask : step
    // Software must see the clear request drop before touching the FIFO again.
    task automatic poll;
        for (int i = 0; i < 20; i++) begin
            rd(1'h0);
            if (d[10] === 1'h0) break;
        end
        chk("fifo_clear_req", d[10], 32'h0);
    endtask : poll
    task automatic results;
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        rd(1'h0);
        chk("control", d, 32'h0060_0400);
        for (int i = 0; i < 8; i++) begin
            wr(1'h0, 4'h8, {i[2:0], 5'h03, 24'h0});
            chk("payload_bytes", payload_bytes, sizes[i]);
        end
        chk("depth_msgs", depth_msgs, 32'h4);
        wr(1'h0, 4'h7, 32'h003f_009f);
        chk("tx_priority", tx_priority, 32'h1f);
        chk("is_transmit", is_transmit, 32'h1);
        @(posedge clk) cfg_mode <= 1'h0;
        poll();
        wr(1'h0, 4'h8, 32'h0);
        chk("payload_bytes", payload_bytes, 32'h40);
        repeat (2) wr(1'h0, 4'h2, 32'h100);
        chk("head_index", head_index, 32'h2);
        wr(1'h0, 4'h2, 32'h200);
        step(6'h01);
        chk("message_slot_index", message_slot_index, 32'h1);
        chk("send_request", send_request, 32'h1);
        step(6'h01);
        chk("send_request", send_request, 32'h0);
        wr(1'h0, 4'h2, 32'h100);
        wr(1'h0, 4'h2, 32'h200);
        wr(1'h0, 4'h2, 32'h000);
        chk("abort_req", abort_seen, 32'h1);
        step(6'h02);
        rd(1'h1);
        chk("aborted_flag", d[7], 32'h1);
        wr(1'h0, 4'h2, 32'h200);
        rd(1'h1);
        chk("aborted_flag", d[7], 32'h0);
        repeat (3) step(6'h04);
        chk("retry_allowed", retry_allowed, 32'h0);
        step(6'h04);
        rd(1'h1);
        chk("status_tx", d[7:4], 32'hd);
        chk("send_request", send_request, 32'h0);
        chk("irq", irq[4], 32'h1);
        wr(1'h1, 4'h1, 32'h0);
        rd(1'h1);
        chk("status_tx", d[7:4], 32'h0);
        step(6'h20);
        chk("send_request", send_request, 32'h0);
        wr(1'h0, 4'h1, 32'h5f);
        step(6'h20);
        chk("send_request", send_request, 32'h1);
        @(posedge clk) cfg_mode <= 1'h1;
        wr(1'h0, 4'h1, 32'h3f);
        chk("ts_store", ts_store, 32'h1);
        @(posedge clk) cfg_mode <= 1'h0;
        poll();
        wr(1'h0, 4'h2, 32'h200);
        chk("send_request", send_request, 32'h0);
        repeat (5) step(6'h10);
        rd(1'h1);
        chk("status_rx", d[12:0], 32'h000f);
        chk("irq", irq[3], 32'h1);
        wr(1'h0, 4'h2, 32'h100);
        chk("tail_index", tail_index, 32'h1);
        wr(1'h0, 4'h2, 32'h400);
        poll();
        chk("tail_index", tail_index, 32'h0);
        results();
    end
endmodule : testbench
bind cmf_fifo_ctrl cmf_fifo_ctrl_monitor u_mon (.clk, .rst_b, .cfg_mode, .send_request,
    .payload_bytes, .depth_msgs, .head_index, .tail_index, .message_slot_index, .ts_store,
    .is_transmit, .irq);
`default_nettype wire
